// ---- lls_ctrl.sv ----
// Purpose: low side protection, link transceiver control, frame port
// Assumes: analog detectors deliver levels; bus 0 = dominant
// Notes:   all pin inputs pass the three stage synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "lls_regs.svh"
module lls_ctrl #(
	parameter int STUCK_MS = 1000
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	input  wire logic       txd,
	input  wire logic       lin_rx,
	input  wire logic       rxd_fb,
	input  wire logic       rxd_short,
	input  wire logic       ls_ot,
	input  wire logic       lin_ot,
	input  wire logic       vsup_ov,
	input  wire logic       vsup_uv,
	input  wire logic       vdd_ot,
	input  wire logic       pwmin,
	input  wire logic [3:0] hs_status,
	input  wire logic [3:0] ls_status,
	output logic            miso,
	output logic            miso_oe,
	output logic            irq_n,
	output logic            rxd,
	output logic            lin_dom,
	output logic [1:0]      ls_drv,
	output logic [1:0]      slew_select,
	output logic            wake_rst
);
	import lls_pkg::*;

	// =============================================
	// timing
	localparam int STUCK_CYC = STUCK_MS * (`LLS_CLK_HZ / 1000);
	localparam logic [`LLS_STUCK_W-1:0] STUCK_N = `LLS_STUCK_W'(STUCK_CYC);
	localparam int WAKE_CYC = `LLS_WAKE_US * (`LLS_CLK_HZ / 1000000);
	localparam logic [`LLS_WAKE_W-1:0] WAKE_N = `LLS_WAKE_W'(WAKE_CYC);

	function automatic logic page_hit(input logic [3:0] a, input logic [2:0] p);
		page_hit = (a[3:1] == p);
	endfunction

	// =============================================
	// input synchronisers
	// polarities chosen so txd, lin_rx and cs_n idle low at reset
	logic [`LLS_NSYNC-1:0] raw;
	logic [`LLS_NSYNC-1:0] syn;
	assign raw = {ls_status, hs_status, vdd_ot, pwmin, rxd_short,
		vsup_uv, vsup_ov, lin_ot, ls_ot, rxd_fb, ~lin_rx, ~txd,
		mosi, ~cs_n, sclk};

	lls_sync #(
		.W (`LLS_NSYNC)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (raw),
		.q      (syn)
	);

	wire       sclk_s   = syn[0];
	wire       cs_s     = syn[1];
	wire       mosi_s   = syn[2];
	wire       txd_dom  = syn[3];
	wire       bus_dom  = syn[4];
	wire       fb_s     = syn[5];
	wire       ls_ot_s  = syn[6];
	wire       lin_ot_s = syn[7];
	wire       ov_s     = syn[8];
	wire       uv_s     = syn[9];
	wire       short_s  = syn[10];
	wire       pwm_s    = syn[11];
	wire       vdd_ot_s = syn[12];
	wire [3:0] hs_s     = syn[16:13];
	wire [3:0] ls_s     = syn[20:17];

	// =============================================
	// registers
	lls_mode_t mode_reg;
	lls_mode_t mode_next;
	logic       overvoltage_shutdown_enable_reg;
	logic [3:0] low_side_control_reg;
	logic       low_side_shut_reg;
	logic       undervoltage_gate_disable_reg;
	logic       receive_only_bit_reg;
	logic [1:0] slew_select_reg;
	logic       link_overtemp_flag_reg;
	logic       receive_short_flag_reg;
	logic       transmit_stuck_flag_reg;
	logic       ot_shut_reg;
	logic       rs_shut_reg;
	logic       st_shut_reg;
	logic [`LLS_STUCK_W-1:0] stuck_cnt_reg;
	logic [`LLS_WAKE_W-1:0]  wake_cnt_reg;
	logic       wake_armed_reg;
	logic       bus_dom_reg;
	logic       fb_reg;
	logic [3:0] interrupt_mask_reg;
	logic [3:0] interrupt_source_reg;
	logic       power_loss_flag_reg;
	logic       irq_n_reg;
	logic       rxd_reg;
	logic       lin_dom_reg;
	logic [1:0] ls_drv_reg;
	logic       wake_rst_reg;

	// =============================================
	// frame port
	logic       f_done;
	logic [3:0] f_addr;
	logic [3:0] f_data;
	logic [3:0] vstat;
	logic [3:0] link_status_reg;
	logic [3:0] summary;

	assign vstat = {ov_s, uv_s, vdd_ot_s, power_loss_flag_reg};
	assign link_status_reg = {receive_short_flag_reg,
		transmit_stuck_flag_reg, link_overtemp_flag_reg, 1'b0};
	assign summary = {|vstat, |link_status_reg, |hs_s, |ls_s}; // RQ25

	lls_spi u_spi (
		.clk     (clk),
		.arst_n  (arst_n),
		.sclk_s  (sclk_s),
		.cs_s    (cs_s),
		.mosi_s  (mosi_s),
		.summary (summary),
		.pages   ({interrupt_source_reg, 8'h00, ls_s, hs_s,
			link_status_reg, 4'h0, vstat}),
		.miso    (miso),
		.miso_oe (miso_oe),
		.done    (f_done),
		.addr    (f_addr),
		.data    (f_data)
	);

	// writes land only on even addresses; any access reads
	wire acc_volt = f_done & page_hit(f_addr, `LLS_PG_VOLT);
	wire acc_link = f_done & page_hit(f_addr, `LLS_PG_LINK);
	wire acc_src  = f_done & page_hit(f_addr, `LLS_PG_MASK);
	wire wr_mode  = acc_volt & ~f_addr[0]; // RQ24
	wire wr_link  = acc_link & ~f_addr[0];
	wire wr_mask  = acc_src & ~f_addr[0];
	wire wr_low   = f_done & ~f_addr[0]
		& page_hit(f_addr, `LLS_PG_LOW);

	// =============================================
	// mode
	wire is_normal = (mode_reg == lls_m_normal);
	wire is_stop   = (mode_reg == lls_m_stop);
	wire is_sleep  = (mode_reg == lls_m_sleep);
	wire irq_mode  = is_normal | is_stop; // RQ26

	// =============================================
	// wake detection
	// a bus glitch shorter than the filter restarts the count
	wire wake_on = is_sleep | (is_stop & ~receive_only_bit_reg); // RQ18
	wire bus_rise = bus_dom_reg & ~bus_dom;
	wire wake_ev = wake_on & wake_armed_reg & bus_rise; // RQ19 RQ20

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_cnt_reg   <= '0;
			wake_armed_reg <= 1'b0;
			bus_dom_reg    <= 1'b0;
		end else begin
			bus_dom_reg <= bus_dom;
			if (!bus_dom || !wake_on) begin
				wake_cnt_reg   <= '0;
				wake_armed_reg <= 1'b0;
			end else if (wake_cnt_reg != WAKE_N) begin
				wake_cnt_reg <= wake_cnt_reg + 1'b1;
			end else begin
				wake_armed_reg <= 1'b1;
			end
		end
	end

	always_comb begin
		mode_next = mode_reg;
		if (wake_ev)
			mode_next = lls_m_normal;
		else if (wr_mode) begin
			unique case (f_data[1:0])
				2'b01: mode_next = lls_m_stop;
				2'b10: mode_next = lls_m_sleep;
				default: mode_next = lls_m_normal;
			endcase
		end
	end

	// =============================================
	// low side drivers
	wire hv_cond  = overvoltage_shutdown_enable_reg & ov_s; // RQ4
	wire ls_cond  = ls_ot_s | hv_cond;
	wire ls_shut_next = ls_cond |
		(low_side_shut_reg & ~wr_low); // RQ1 RQ3 RQ4
	wire [1:0] ls_drv_next;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ls
			assign ls_drv_next[gi] = low_side_control_reg[gi]
				& (~low_side_control_reg[gi+2] | pwm_s)
				& is_normal & ~low_side_shut_reg; // RQ5 RQ1
		end
	endgenerate

	// =============================================
	// link transmitter protection
	wire stuck_hit = txd_dom & (stuck_cnt_reg == STUCK_N); // RQ15
	wire ot_ev = lin_ot_s & ~link_overtemp_flag_reg; // RQ10
	// shutdown even while an earlier short is still unread
	wire rs_hit = short_s & lin_dom_reg;
	wire rs_ev = rs_hit & ~receive_short_flag_reg; // RQ13
	wire st_ev = stuck_hit & ~transmit_stuck_flag_reg;
	wire link_err = ot_ev | rs_ev | st_ev;
	wire fb_toggle = fb_s ^ fb_reg;
	// gate only while recessive so a running dominant bit ends
	wire uv_gate = ~undervoltage_gate_disable_reg & uv_s
		& ~txd_dom; // RQ8 RQ9
	wire tx_en = is_normal & ~receive_only_bit_reg & ~ot_shut_reg
		& ~rs_shut_reg & ~st_shut_reg & ~uv_gate; // RQ17
	wire rx_follow = is_normal | (is_stop & receive_only_bit_reg); // RQ18

	wire ot_shut_next = lin_ot_s |
		(ot_shut_reg & txd_dom); // RQ10 RQ11
	wire rs_shut_next = rs_hit |
		(rs_shut_reg & ~(fb_toggle & ~txd_dom)); // RQ13 RQ14
	wire st_shut_next = stuck_hit |
		(st_shut_reg & txd_dom); // RQ15 RQ16

	wire ot_flag_next = lin_ot_s |
		(link_overtemp_flag_reg & ~acc_link);
	wire rs_flag_next = rs_ev |
		(receive_short_flag_reg & ~(acc_link & ~short_s)); // RQ14
	wire st_flag_next = stuck_hit |
		(transmit_stuck_flag_reg & ~(acc_link & ~txd_dom)); // RQ16

	wire rxo_next = link_err | (wr_link ? f_data[`LLS_B_RXO]
		: receive_only_bit_reg); // RQ17

	// =============================================
	// interrupt sources
	// masked events never reach the source bits
	wire [3:0] src_set;
	assign src_set[`LLS_S_LINK] = link_err & irq_mode
		& interrupt_mask_reg[`LLS_B_LINK_IRQ_MASK]; // RQ12 RQ26
	assign src_set[`LLS_S_LOW] = ls_ot_s & irq_mode
		& interrupt_mask_reg[`LLS_B_LSM]; // RQ1 RQ2 RQ26
	assign src_set[`LLS_S_WAKE] = wake_ev; // RQ19 RQ20
	assign src_set[3] = 1'b0;
	wire [3:0] src_next = src_set |
		(interrupt_source_reg & ~{4{acc_src}});

	// =============================================
	// state update
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg                        <= lls_m_normal;
			overvoltage_shutdown_enable_reg <= `LLS_OVERVOLTAGE_SHUTDOWN_ENABLE_RST;
			low_side_control_reg            <= 4'h0;
			low_side_shut_reg               <= 1'b0;
			undervoltage_gate_disable_reg   <= 1'b0; // RQ7
			receive_only_bit_reg            <= 1'b0;
			slew_select_reg                 <= `LLS_SLEW_RST; // RQ6
			interrupt_mask_reg              <= 4'h0;
			power_loss_flag_reg             <= 1'b1;
		end else begin
			mode_reg             <= mode_next;
			low_side_shut_reg    <= ls_shut_next;
			receive_only_bit_reg <= rxo_next;
			power_loss_flag_reg  <= power_loss_flag_reg & ~acc_volt;
			if (wr_mode)
				overvoltage_shutdown_enable_reg <= f_data[`LLS_B_OVERVOLTAGE_SHUTDOWN_ENABLE];
			if (wr_low)
				low_side_control_reg <= f_data; // RQ3
			if (wr_mask)
				interrupt_mask_reg <= f_data;
			if (wr_link) begin
				undervoltage_gate_disable_reg <= f_data[`LLS_B_UGD]; // RQ7
				slew_select_reg <= f_data[1:0]; // RQ6
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link_overtemp_flag_reg  <= 1'b0;
			receive_short_flag_reg  <= 1'b0;
			transmit_stuck_flag_reg <= 1'b0;
			ot_shut_reg             <= 1'b0;
			rs_shut_reg             <= 1'b0;
			st_shut_reg             <= 1'b0;
			fb_reg                  <= 1'b0;
			interrupt_source_reg    <= 4'h0;
		end else begin
			link_overtemp_flag_reg  <= ot_flag_next;
			receive_short_flag_reg  <= rs_flag_next;
			transmit_stuck_flag_reg <= st_flag_next;
			ot_shut_reg             <= ot_shut_next;
			rs_shut_reg             <= rs_shut_next;
			st_shut_reg             <= st_shut_next;
			fb_reg                  <= fb_s;
			interrupt_source_reg    <= src_next;
		end
	end

	// saturating so a stuck input flags once and stays flagged
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			stuck_cnt_reg <= '0;
		else if (!txd_dom)
			stuck_cnt_reg <= '0;
		else if (stuck_cnt_reg != STUCK_N)
			stuck_cnt_reg <= stuck_cnt_reg + 1'b1; // RQ15
	end

	// =============================================
	// registered outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_n_reg    <= 1'b1;
			rxd_reg      <= 1'b1;
			lin_dom_reg  <= 1'b0;
			ls_drv_reg   <= 2'h0;
			wake_rst_reg <= 1'b0;
		end else begin
			irq_n_reg    <= ~|src_next; // RQ2 RQ12
			rxd_reg      <= uv_gate | ~rx_follow | ~bus_dom; // RQ8 RQ18
			lin_dom_reg  <= tx_en & txd_dom; // RQ8 RQ10 RQ13 RQ17
			ls_drv_reg   <= ls_drv_next;
			wake_rst_reg <= wake_ev & is_sleep; // RQ20
		end
	end

	assign irq_n       = irq_n_reg;
	assign rxd         = rxd_reg;
	assign lin_dom     = lin_dom_reg;
	assign ls_drv      = ls_drv_reg;
	assign slew_select = slew_select_reg;
	assign wake_rst    = wake_rst_reg;
endmodule
`default_nettype wire

// ---- lls_regs.svh ----
// Purpose: constants of the low side / link control block
// Assumes: 20 MHz core clock
// Notes:   offsets, fields, reset values and timing counts
//
// Function
// RQ1 - low side overtemp: drivers off, source latched
// RQ2 - low side mask set: latched event asserts irq
// RQ3 - re-enable needs control write and overtemp gone
// RQ4 - overvoltage shutdown when enabled; write re-enables
// RQ5 - low side drivers off in sleep, stop
// RQ6 - slew field drives slope; reset selects 20k
// RQ7 - undervoltage gate disable defaults zero
// RQ8 - undervoltage with recessive input: transmitter off, rx high
// RQ9 - no undervoltage gating while input dominant
// RQ10 - link overtemp: transmitter off, flag set
// RQ11 - overtemp recovery when gone and input high
// RQ12 - link mask set: link flag events raise irq
// RQ13 - receive short while sending: flag, transmitter off
// RQ14 - short recovery on rx toggle; read clears
// RQ15 - input low over one second: stuck flag, off
// RQ16 - stuck recovery on input high; read clears
// RQ17 - receive only blocks transmitter; errors set it
// RQ18 - stop with receive only: no wake, rx follows
// RQ19 - stop: long dominant then rise gives wake source
// RQ20 - sleep: long dominant then rise gives reset
// RQ21 - byte frame: address, control; summary, status
// RQ22 - shift on rising, sample falling; cs fall snapshots
// RQ23 - valid only with exactly eight sampling edges
// RQ24 - cs rise writes register; miso released
// RQ25 - summary bit set when its register nonzero
// RQ26 - irq only normal, stop; masked sets nothing
// RQ27 - wrong edge count frame is dropped
// RQ28 - most significant bit first, address first
`ifndef LLS_REGS_SVH
`define LLS_REGS_SVH
`define LLS_CLK_HZ       20000000
`define LLS_WAKE_US      100
`define LLS_WAKE_W       12
`define LLS_STUCK_W      25
`define LLS_NSYNC        21
`define LLS_SPI_BITS     4'h8
`define LLS_SPI_ADDR_AT  4'h3
`define LLS_PG_VOLT      3'h0
`define LLS_PG_LINK      3'h2
`define LLS_PG_LOW       3'h4
`define LLS_PG_MASK      3'h7
`define LLS_B_OVERVOLTAGE_SHUTDOWN_ENABLE       3
`define LLS_B_UGD        3
`define LLS_B_RXO        2
`define LLS_B_LSM        2
`define LLS_B_LINK_IRQ_MASK       1
`define LLS_S_LINK       0
`define LLS_S_LOW        1
`define LLS_S_WAKE       2
`define LLS_OVERVOLTAGE_SHUTDOWN_ENABLE_RST     1'h1
`define LLS_SLEW_RST     2'h0
`endif

// ---- lls_pkg.sv ----
// Purpose: shared types of the low side / link control block
// Assumes: nothing
// Notes:   gray coded mode along normal, stop, sleep
package lls_pkg;
	typedef enum logic [1:0] {
		lls_m_normal = 2'b00,
		lls_m_stop   = 2'b01,
		lls_m_sleep  = 2'b11
	} lls_mode_t;
endpackage

// ---- lls_sync.sv ----
// Purpose: three stage input synchroniser
// Assumes: all inputs idle low at reset
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module lls_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;
	// per bit agreement filters a single late sample
	wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);
	wire  [W-1:0] q_next = (agree & s3_reg) | (~agree & q_reg);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_reg  <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg  <= q_next;
		end
	end
	assign q = q_reg;
endmodule
`default_nettype wire

// ---- lls_spi.sv ----
// Purpose: byte frame slave timed by the sampled serial clock
// Assumes: sclk idles low, inputs already synchronised
// Notes:   done pulses one cycle after cs rise on a good frame
`timescale 1ns/1ps
`default_nettype none
`include "lls_regs.svh"
module lls_spi (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        sclk_s,
	input  wire logic        cs_s,
	input  wire logic        mosi_s,
	input  wire logic [3:0]  summary,
	input  wire logic [31:0] pages,
	output logic             miso,
	output logic             miso_oe,
	output logic             done,
	output logic [3:0]       addr,
	output logic [3:0]       data
);
	logic [1:0]  sclk_reg;
	logic        cs_reg;
	logic [3:0]  cnt_reg;
	logic [7:0]  rx_reg;
	logic [3:0]  a_reg;
	logic [35:0] snap_reg;
	logic        miso_reg;
	logic        oe_reg;
	logic        done_reg;
	wire         cs_fall = cs_s & ~cs_reg;
	wire         cs_rise = ~cs_s & cs_reg;
	wire         s_rise = cs_s & ~sclk_reg[1] & sclk_reg[0];
	wire         s_fall = cs_s & sclk_reg[1] & ~sclk_reg[0];
	wire [3:0]   nib = snap_reg[{a_reg[3:1], 2'h0} +: 4];
	wire [7:0]   obyte = {snap_reg[35:32], nib};
	wire [2:0]   bitx = 3'(4'h7 - cnt_reg);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_reg <= 2'h0;
			cs_reg   <= 1'b0;
			cnt_reg  <= 4'h0;
			rx_reg   <= 8'h00;
			a_reg    <= 4'h0;
			snap_reg <= 36'h0;
			miso_reg <= 1'b0;
			oe_reg   <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			sclk_reg <= {sclk_reg[0], sclk_s};
			cs_reg   <= cs_s;
			done_reg <= cs_rise & (cnt_reg == `LLS_SPI_BITS); // RQ23 RQ27
			if (cs_fall) begin
				snap_reg <= {summary, pages}; // RQ22
				cnt_reg  <= 4'h0;
				oe_reg   <= 1'b1;
				miso_reg <= summary[3];
			end else if (cs_rise) begin
				oe_reg <= 1'b0; // RQ24
			end else if (s_fall) begin
				rx_reg <= {rx_reg[6:0], mosi_s}; // RQ28
				if (cnt_reg != 4'hf)
					cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == `LLS_SPI_ADDR_AT)
					a_reg <= {rx_reg[2:0], mosi_s};
			end else if (s_rise && cnt_reg != 4'h0 && cnt_reg < `LLS_SPI_BITS) begin
				miso_reg <= obyte[bitx]; // RQ21 RQ22
			end
		end
	end
	assign miso    = miso_reg;
	assign miso_oe = oe_reg;
	assign done    = done_reg;
	assign addr    = rx_reg[7:4];
	assign data    = rx_reg[3:0];
endmodule
`default_nettype wire

// ---- lls_ctrl_properties.sv ----
// Purpose: port-level properties of lls_ctrl
// Assumes: single clock domain, async active low reset
// Notes:   windows allow for the three stage input sync
`timescale 1ns/1ps
`default_nettype none
module lls_ctrl_properties #(
	parameter int STUCK_MS = 1000
) (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       cs_n,
	input wire logic       txd,
	input wire logic       rxd_short,
	input wire logic       ls_ot,
	input wire logic       lin_ot,
	input wire logic       miso_oe,
	input wire logic       lin_dom,
	input wire logic       wake_rst,
	input wire logic [1:0] ls_drv,
	input wire logic [1:0] slew_select
);
	// margin covers sync depth plus output register
	localparam int LIM = STUCK_MS * 20000 + 40;
	int lo_cnt_reg;
	// ====================
	// txd low time
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			lo_cnt_reg <= 0;
		else if (txd)
			lo_cnt_reg <= 0;
		else
			lo_cnt_reg <= lo_cnt_reg + 1;
	end
	// ====================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_cs_fall; $fell(cs_n) ##1 !cs_n[*7]; endsequence
	sequence s_cs_idle; cs_n[*7]; endsequence
	sequence s_short; (lin_dom && rxd_short)[*2]; endsequence
	property p_miso_drive; s_cs_fall |-> miso_oe; endproperty
	a_miso_drive: assert property (p_miso_drive) else $error("miso not driven in frame");
	property p_miso_release; s_cs_idle |-> !miso_oe; endproperty
	a_miso_release: assert property (p_miso_release) else $error("miso driven while idle");
	property p_ls_ot; ls_ot[*8] |-> ls_drv == 2'h0; endproperty
	a_ls_ot: assert property (p_ls_ot) else $error("low side on during overtemp");
	property p_lin_ot; lin_ot[*8] |-> !lin_dom; endproperty
	a_lin_ot: assert property (p_lin_ot) else $error("bus driven during overtemp");
	property p_short; s_short |-> ##[1:8] !lin_dom; endproperty
	a_short: assert property (p_short) else $error("bus driven with rx short");
	property p_stuck; (lo_cnt_reg > LIM) |-> !lin_dom; endproperty
	a_stuck: assert property (p_stuck) else $error("bus driven after stuck time");
	property p_recessive; txd[*8] |-> !lin_dom; endproperty
	a_recessive: assert property (p_recessive) else $error("bus dominant with txd high");
	property p_slew_rst; $rose(arst_n) |-> slew_select == 2'h0; endproperty
	a_slew_rst: assert property (p_slew_rst) else $error("slew not default after reset");
	property p_wake_pulse; wake_rst |=> !wake_rst; endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake reset longer than a cycle");
endmodule
bind lls_ctrl lls_ctrl_properties #(.STUCK_MS(STUCK_MS)) u_props (
	.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .txd(txd), .rxd_short(rxd_short),
	.ls_ot(ls_ot), .lin_ot(lin_ot), .miso_oe(miso_oe), .lin_dom(lin_dom),
	.wake_rst(wake_rst), .ls_drv(ls_drv), .slew_select(slew_select)
);
`default_nettype wire

// ---- lls_host.sv ----
// Purpose: serial master model on the frame port
// Assumes: 400 ns sclk, sclk idles low between frames
// Notes:   pulse count is a task argument to make bad frames
`timescale 1ns/1ps
`default_nettype none
module lls_host (
	input  wire logic clk,
	input  wire logic miso,
	input  wire logic miso_oe,
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// ====================
	// one frame, n sampling edges
	task automatic frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		@(negedge clk);
		cs_n = 1'b0;
		repeat (8) @(negedge clk);
		for (int k = 0; k < n; k++) begin
			sclk = 1'b1;
			mosi = (k < 8) ? tx[7 - k] : 1'b0;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
			// read late in the low half: miso lags sclk by the sync depth
			repeat (4) @(negedge clk);
			if (k < 8)
				rx[7 - k] = miso_oe ? miso : 1'bx;
		end
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (14) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: directed test of lls_ctrl through its frame port
// Assumes: STUCK_MS of 1, fixed waits sized to sync latency
// Notes:   analog detector inputs driven as levels
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       clk, arst_n, sclk, cs_n, mosi, txd, lin_rx, rxd_fb, rxd_short;
	logic       ls_ot, lin_ot, vsup_ov, vsup_uv, vdd_ot, pwmin, saw_wr;
	logic       miso, miso_oe, irq_n, rxd, lin_dom, wake_rst;
	logic [3:0] hs_status, ls_status;
	logic [1:0] ls_drv, slew_select;
	logic [7:0] r;
	int         n_mismatch, checked, cyc;
	lls_ctrl #(.STUCK_MS(1)) u_lls_ctrl (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .txd(txd), .lin_rx(lin_rx), .rxd_fb(rxd_fb), .rxd_short(rxd_short),
		.ls_ot(ls_ot), .lin_ot(lin_ot), .vsup_ov(vsup_ov), .vsup_uv(vsup_uv), .vdd_ot(vdd_ot),
		.pwmin(pwmin), .hs_status(hs_status), .ls_status(ls_status), .miso(miso),
		.miso_oe(miso_oe), .irq_n(irq_n), .rxd(rxd), .lin_dom(lin_dom), .ls_drv(ls_drv),
		.slew_select(slew_select), .wake_rst(wake_rst));
	lls_host u_lls_host (.clk(clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
	// ====================
	// clock, timeout, pulse catcher
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (wake_rst === 1'b1)
			saw_wr <= 1'b1;
	end
	// whole run is about 29500 cycles
	always @(negedge clk) if (cyc == 50000) begin
		n_mismatch++;
		end_sim();
	end
	// ====================
	// tasks
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic xf(input logic [7:0] tx, input logic [7:0] e);
		u_lls_host.frame(tx, 8, r);
		ck(r, e);
	endtask
	task end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ====================
	// sequence
	initial begin
		{n_mismatch, checked, cyc, saw_wr} = '0;
		{arst_n, txd, lin_rx, rxd_fb, pwmin} = 5'h0f;
		{rxd_short, ls_ot, lin_ot, vsup_ov, vsup_uv, vdd_ot} = 6'h00;
		{hs_status, ls_status} = 8'h00;
		w(4);
		arst_n = 1'b1;
		w(6);
		ck({6'h0, slew_select}, 8'h00);
		xf(8'h10, 8'h81);
		xf(8'h10, 8'h00);
		{hs_status, ls_status, vdd_ot} = 9'h14b;
		w(10);
		xf(8'h70, 8'hba);
		xf(8'h90, 8'hb5);
		xf(8'h10, 8'hb2);
		{hs_status, ls_status, vdd_ot} = 9'h000;
		w(10);
		xf(8'hc3, 8'h00);
		xf(8'h43, 8'h00);
		ck({6'h0, slew_select}, 8'h03);
		u_lls_host.frame(8'h41, 7, r);
		u_lls_host.frame(8'h41, 9, r);
		ck({6'h0, slew_select}, 8'h03);
		ls_ot = 1'b1;
		w(10);
		ck({7'h0, irq_n}, 8'h01);
		ls_ot = 1'b0;
		w(10);
		xf(8'he4, 8'h00);
		xf(8'h83, 8'h00);
		ls_ot = 1'b1;
		w(10);
		ck({6'h0, ls_drv}, 8'h00);
		ck({7'h0, irq_n}, 8'h00);
		ls_ot = 1'b0;
		w(10);
		ck({6'h0, ls_drv}, 8'h00);
		xf(8'hf0, 8'h02);
		xf(8'h83, 8'h00);
		ck({6'h0, ls_drv}, 8'h03);
		vsup_ov = 1'b1;
		w(10);
		ck({6'h0, ls_drv}, 8'h00);
		vsup_ov = 1'b0;
		w(10);
		ck({6'h0, ls_drv}, 8'h00);
		xf(8'h83, 8'h00);
		ck({6'h0, ls_drv}, 8'h03);
		xf(8'h85, 8'h00);
		ck({6'h0, ls_drv}, 8'h01);
		pwmin = 1'b0;
		w(10);
		ck({6'h0, ls_drv}, 8'h00);
		pwmin = 1'b1;
		xf(8'h09, 8'h00);
		ck({6'h0, ls_drv}, 8'h00);
		lin_rx = 1'b0;
		w(2100);
		lin_rx = 1'b1;
		w(10);
		ck({7'h0, irq_n}, 8'h00);
		xf(8'hf0, 8'h04);
		xf(8'h0a, 8'h00);
		lin_rx = 1'b0;
		w(2100);
		lin_rx = 1'b1;
		w(10);
		ck({7'h0, saw_wr}, 8'h01);
		xf(8'hf0, 8'h04);
		xf(8'he6, 8'h00);
		txd = 1'b0;
		w(10);
		ck({7'h0, lin_dom}, 8'h01);
		lin_ot = 1'b1;
		w(10);
		ck({7'h0, lin_dom}, 8'h00);
		ck({7'h0, irq_n}, 8'h00);
		lin_ot = 1'b0;
		w(10);
		ck({7'h0, lin_dom}, 8'h00);
		txd = 1'b1;
		w(10);
		txd = 1'b0;
		w(10);
		ck({7'h0, lin_dom}, 8'h00);
		txd = 1'b1;
		xf(8'h50, 8'h42);
		xf(8'hf0, 8'h01);
		xf(8'h43, 8'h00);
		txd = 1'b0;
		w(10);
		ck({7'h0, lin_dom}, 8'h01);
		rxd_short = 1'b1;
		w(10);
		ck({7'h0, lin_dom}, 8'h00);
		{rxd_short, txd, rxd_fb} = 3'h2;
		w(10);
		xf(8'h50, 8'h48);
		xf(8'hf0, 8'h01);
		xf(8'h43, 8'h00);
		txd = 1'b0;
		w(10);
		ck({7'h0, lin_dom}, 8'h01);
		w(20090);
		ck({7'h0, lin_dom}, 8'h00);
		txd = 1'b1;
		w(10);
		xf(8'h50, 8'h44);
		xf(8'hf0, 8'h01);
		xf(8'h43, 8'h00);
		txd = 1'b0;
		w(10);
		vsup_uv = 1'b1;
		w(10);
		ck({7'h0, lin_dom}, 8'h01);
		{txd, lin_rx} = 2'h2;
		w(10);
		ck({6'h0, rxd, lin_dom}, 8'h02);
		xf(8'h4b, 8'h80);
		ck({7'h0, rxd}, 8'h00);
		{vsup_uv, lin_rx} = 2'h1;
		xf(8'h47, 8'h00);
		xf(8'h09, 8'h00);
		lin_rx = 1'b0;
		w(2100);
		ck({7'h0, rxd}, 8'h00);
		lin_rx = 1'b1;
		w(10);
		ck({6'h0, irq_n, ls_drv[0]}, 8'h02);
		xf(8'h08, 8'h00);
		ck({6'h0, ls_drv}, 8'h01);
		end_sim();
	end
endmodule
`default_nettype wire
